// >>> bench/dsrb_host_model.sv
// Purpose: Serial master model for the register bank port
// Assumes: Paced by ref_clk falling edges, 160 ns serial period
// Notes:   Released data line toggles so stale bits never match
`timescale 1ns/1ps
module dsrb_host_model (
  input  wire logic clk,
  input  wire logic dataBack,
  output logic      sclk,
  output logic      selLow_b,
  output logic      resync,
  output logic      sdi,
  output logic      upd
);
  import dsrb_pkg::*;
  logic lsb = 1'b0;
  initial begin
    sclk = 1'b0;
    selLow_b = 1'b1;
    resync = 1'b0;
    sdi = 1'b0;
    upd = 1'b0;
  end
  // ====================
  // Bus cycles
  task automatic hp();
    repeat (8) @(negedge clk);
  endtask
  task automatic xbyte(input logic [7:0] t, input logic rd,
                       output logic [7:0] r);
    int b;
    for (int i = 0; i < 8; i++) begin
      b = lsb ? i : 7 - i;
      sdi = rd ? ~sdi : t[b];
      hp();
      r[b] = dataBack;
      sclk = 1'b1;
      hp();
      // Clock rests low between bytes and frames
      sclk = 1'b0;
    end
  endtask
  task automatic sel(input logic v);
    selLow_b = v;
    hp();
  endtask
  task automatic access(input logic rd, input logic [4:0] a,
                        input logic [31:0] wv, output logic [31:0] rv);
    logic [7:0] d;
    int         k;
    int         n;
    n = int'(DSRB_REG_LEN[a]);
    rv = '0;
    xbyte({rd, 2'b00, a}, 1'b0, d);
    for (int j = 0; j < n; j++) begin
      k = lsb ? j : n - 1 - j;
      xbyte(wv[8*k +: 8], rd, d);
      rv[8*k +: 8] = d;
    end
  endtask
  task automatic frame(input logic rd, input logic [4:0] a,
                       input logic [31:0] wv, output logic [31:0] rv);
    sel(1'b0);
    access(rd, a, wv, rv);
    sel(1'b1);
  endtask
  task automatic update();
    upd = 1'b1;
    hp();
    upd = 1'b0;
    hp();
  endtask
  task automatic resyncPulse();
    resync = 1'b1;
    hp();
    resync = 1'b0;
    hp();
  endtask
endmodule

// >>> bench/dsrb_serial_bank_checker.sv
// Purpose: Concurrent checks on the serial register bank ports
// Assumes: One ref_clk domain, rst_b asynchronous active low
// Notes:   Bounds allow for the two-cycle pin synchroniser lag
`timescale 1ns/1ps
module dsrb_serial_bank_checker (
  input wire logic                  ref_clk,
  input wire logic                  rst_b,
  input wire logic                  chipSelectLow_b,
  input wire logic                  serialResyncInput,
  input wire logic                  ioUpdate,
  input wire logic                  serialDataOe,
  input wire logic                  serialOutputPin,
  input wire dsrb_pkg::dsrb_active_s activeRegs
);
  import dsrb_pkg::*;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);
  logic [3:0] updAge_r;
  logic [3:0] updAge_nxt;
  logic       updPrev_r;
  logic       updPrev_nxt;
  // ====================
  // Cycles since update pin rose
  always_comb begin
    updPrev_nxt = ioUpdate;
    updAge_nxt = (updAge_r == 4'hf) ? updAge_r : updAge_r + 4'h1;
    if (ioUpdate && !updPrev_r)
      updAge_nxt = 4'h0;
  end
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      updAge_r  <= 4'hf;
      updPrev_r <= 1'b0;
    end else begin
      updAge_r  <= updAge_nxt;
      updPrev_r <= updPrev_nxt;
    end
  end
  property p_oe_mode;
    serialDataOe |-> !activeRegs.controlWordOne[9];
  endproperty
  a_oe_mode: assert property (p_oe_mode)
    else $error("data pin driven in three-wire mode");
  property p_cs_idle;
    chipSelectLow_b [*6] |-> !serialDataOe;
  endproperty
  a_cs_idle: assert property (p_cs_idle)
    else $error("data pin driven while deselected");
  property p_out_idle;
    chipSelectLow_b [*6] |-> !serialOutputPin;
  endproperty
  a_out_idle: assert property (p_out_idle)
    else $error("output pin active while deselected");
  property p_resync;
    serialResyncInput [*6] |-> !serialDataOe && !serialOutputPin;
  endproperty
  a_resync: assert property (p_resync)
    else $error("read continues during resync");
  property p_pll;
    $stable(activeRegs.controlWordTwo) [*3] |->
      activeRegs.pllMultiplier == activeRegs.controlWordTwo[7:3] &&
      activeRegs.pllBypass == (activeRegs.pllMultiplier < 5'h04 ||
                               activeRegs.pllMultiplier > 5'h14);
  endproperty
  a_pll: assert property (p_pll)
    else $error("multiplier field decode wrong");
  property p_open;
    (activeRegs.controlWordOne & ~DSRB_BYTE_MASK[3:0]) == '0 &&
      (activeRegs.controlWordTwo & ~DSRB_BYTE_MASK[6:4]) == '0;
  endproperty
  a_open: assert property (p_open)
    else $error("open control bit set");
  property p_upd;
    !$stable(activeRegs[131:6]) |-> updAge_r <= 4'h6;
  endproperty
  a_upd: assert property (p_upd)
    else $error("active registers changed without update");
  property p_rst;
    $rose(rst_b) |-> activeRegs[131:6] == '0 && !serialDataOe;
  endproperty
  a_rst: assert property (p_rst)
    else $error("registers not cleared by reset");
  c_read: cover property ($rose(serialDataOe));
  c_lsb: cover property (activeRegs.controlWordOne[8]);
  c_three: cover property (activeRegs.controlWordOne[9] && serialOutputPin);
endmodule

bind dsrb_serial_bank dsrb_serial_bank_checker u_chk (
  .ref_clk, .rst_b, .chipSelectLow_b, .serialResyncInput, .ioUpdate,
  .serialDataOe, .serialOutputPin, .activeRegs
);

// >>> bench/tb_dds_serial_register_bank.sv
// Purpose: Self-checking bench for the serial register bank
// Assumes: Host model drives the port from ref_clk falling edges
// Notes:   Row table covers readback and update of every register
`timescale 1ns/1ps
module tb_dds_serial_register_bank;
  import dsrb_pkg::*;
  typedef struct {
    logic [4:0]  addr;
    logic [31:0] wv;
    logic [31:0] exp;
  } dsrb_row_s;
  logic         ref_clk = 1'b0;
  logic         rst_b = 1'b0;
  logic         serialClock;
  logic         chipSelectLow_b;
  logic         serialResyncInput;
  logic         hostData;
  logic         ioUpdate;
  logic         serialDataOut;
  logic         serialDataOe;
  logic         serialOutputPin;
  logic         threeWire = 1'b0;
  dsrb_active_s activeRegs;
  int           num_errors = 0;
  int           checked = 0;
  int           cycles = 0;
  logic [31:0]  rv;
  logic [4:0]   pll [4] = '{5'h03, 5'h04, 5'h14, 5'h15};
  dsrb_row_s    rows [6] = '{
    '{5'h00, 32'hfffffcff, 32'h07df34ba},
    '{5'h01, 32'h00ffffff, 32'h00000fff},
    '{5'h02, 32'h0000ffff, 32'h0000ffff},
    '{5'h03, 32'h000000ab, 32'h000000ab},
    '{5'h04, 32'h12345678, 32'h12345678},
    '{5'h05, 32'h0000ffff, 32'h00003fff}};
  // Device drives the shared pin only while its enable is high
  wire          dataWire = serialDataOe ? serialDataOut : hostData;

  always #5 ref_clk = ~ref_clk;

  dsrb_serial_bank u_dut (
    .ref_clk(ref_clk), .rst_b(rst_b), .serialClock(serialClock),
    .chipSelectLow_b(chipSelectLow_b),
    .serialResyncInput(serialResyncInput), .serialDataIn(dataWire),
    .ioUpdate(ioUpdate), .serialDataOut(serialDataOut),
    .serialDataOe(serialDataOe), .serialOutputPin(serialOutputPin),
    .activeRegs(activeRegs));
  dsrb_host_model h (
    .clk(ref_clk), .dataBack(threeWire ? serialOutputPin : dataWire),
    .sclk(serialClock), .selLow_b(chipSelectLow_b),
    .resync(serialResyncInput), .sdi(hostData), .upd(ioUpdate));

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("Checks made %0d, errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Run is near 13400 cycles; ceiling leaves wide margin
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 60000) begin
      num_errors++;
      test_done();
    end
  end
  // ====================
  // Main sequence
  initial begin
    repeat (8) @(negedge ref_clk);
    rst_b = 1'b1;
    repeat (4) @(negedge ref_clk);
    foreach (rows[i]) begin
      h.frame(1'b0, rows[i].addr, rows[i].wv, rv);
      h.frame(1'b1, rows[i].addr, 32'h0, rv);
      chk("readback", rv, rows[i].exp);
    end
    chk("held", activeRegs.tuningWord, 32'h0);
    h.update();
    chk("cw1", activeRegs.controlWordOne, 32'h07df34ba);
    chk("cw2", 32'(activeRegs.controlWordTwo), 32'h00000fff);
    chk("scale", 32'({activeRegs.rampSpeed, activeRegs.ampScale}),
        32'h0000ffff);
    chk("ramp", 32'(activeRegs.ampRampRate), 32'h000000ab);
    chk("tune", activeRegs.tuningWord, 32'h12345678);
    chk("phase", 32'(activeRegs.phaseOffset), 32'h00003fff);
    foreach (pll[i]) begin
      h.frame(1'b0, 5'h01, {24'h0, pll[i], 3'h0}, rv);
      h.update();
      chk("mult", 32'(activeRegs.pllMultiplier), 32'(pll[i]));
      chk("bypass", 32'(activeRegs.pllBypass),
          {31'h0, pll[i] < 5'h04 || pll[i] > 5'h14});
    end
    h.sel(1'b0);
    h.xbyte(8'h06, 1'b0, rv[7:0]);
    h.access(1'b0, 5'h03, 32'h5a, rv);
    h.sel(1'b1);
    h.frame(1'b1, 5'h03, 32'h0, rv);
    chk("unmapped", rv, 32'h5a);
    // Select lost in a read, or resync in a write or read, must end it
    h.sel(1'b0);
    h.xbyte(8'h83, 1'b0, rv[7:0]);
    h.sel(1'b1);
    h.sel(1'b0);
    h.xbyte(8'h04, 1'b0, rv[7:0]);
    h.xbyte(8'haa, 1'b0, rv[7:0]);
    h.xbyte(8'hbb, 1'b0, rv[7:0]);
    h.resyncPulse();
    h.xbyte(8'h83, 1'b0, rv[7:0]);
    h.resyncPulse();
    h.access(1'b1, 5'h04, 32'h0, rv);
    h.sel(1'b1);
    chk("abort", rv, 32'haabb5678);
    h.frame(1'b0, 5'h00, 32'h100, rv);
    h.update();
    h.lsb = 1'b1;
    h.frame(1'b0, 5'h04, 32'hcafef00d, rv);
    h.frame(1'b1, 5'h04, 32'h0, rv);
    chk("lsbread", rv, 32'hcafef00d);
    h.update();
    chk("lsbtune", activeRegs.tuningWord, 32'hcafef00d);
    h.frame(1'b0, 5'h00, 32'h300, rv);
    h.update();
    threeWire = 1'b1;
    h.frame(1'b1, 5'h03, 32'h0, rv);
    chk("threewire", rv, 32'h5a);
    rst_b = 1'b0;
    repeat (2) @(negedge ref_clk);
    chk("rst", activeRegs.tuningWord | 32'(activeRegs.phaseOffset),
        32'h0);
    rst_b = 1'b1;
    h.lsb = 1'b0;
    threeWire = 1'b0;
    repeat (4) @(negedge ref_clk);
    h.frame(1'b1, 5'h05, 32'h0, rv);
    chk("rstbuf", rv, 32'h0);
    test_done();
  end
endmodule

// >>> src/dsrb_pkg.sv
// Purpose: Shared constants and types of the serial register bank
// Assumes: Byte-wide internal storage, six serial registers
// Notes:   Packed arrays are indexed by serial or internal byte address
package dsrb_pkg;

  // ==========================================================
  // Geometry
  localparam int unsigned DSRB_BYTE_W    = 8;
  localparam int unsigned DSRB_NUM_BYTES = 16;
  localparam int unsigned DSRB_NUM_REGS  = 6;

  // Instruction byte layout
  localparam int unsigned     DSRB_INSTR_READ_BIT = 7;
  localparam logic [4:0]      DSRB_ADDR_LAST      = 5'h05;

  // ==========================================================
  // Per-register first internal byte and byte count
  localparam logic [5:0][3:0] DSRB_REG_BASE =
    {4'he, 4'ha, 4'h9, 4'h7, 4'h4, 4'h0};
  localparam logic [5:0][2:0] DSRB_REG_LEN  =
    {3'h2, 3'h4, 3'h1, 3'h2, 3'h3, 3'h4};

  // Writable bits per internal byte; open bits stay zero
  localparam logic [15:0][7:0] DSRB_BYTE_MASK = {
    8'h3f, 8'hff,                   // phase offset
    8'hff, 8'hff, 8'hff, 8'hff,     // frequency tuning
    8'hff,                          // ramp rate
    8'hff, 8'hff,                   // amplitude scale
    8'h00, 8'h0f, 8'hff,            // control word two
    8'h07, 8'hdf, 8'h37, 8'hba      // control word one
  };
  localparam logic [7:0] DSRB_BYTE_RST = 8'h00;

  // Serial mode bits in control word one, byte 1
  localparam logic [3:0]  DSRB_MODE_BYTE       = 4'h1;
  localparam int unsigned DSRB_LSB_FIRST_BIT   = 0;
  localparam int unsigned DSRB_INPUT_ONLY_BIT  = 1;

  // Reference multiplier field in control word two
  localparam int unsigned DSRB_PLL_MSB = 7;
  localparam int unsigned DSRB_PLL_LSB = 3;
  localparam logic [4:0]  DSRB_PLL_MIN = 5'h04;
  localparam logic [4:0]  DSRB_PLL_MAX = 5'h14;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    ST_INSTR = 2'b00,
    ST_WRITE = 2'b01,
    ST_READ  = 2'b10
  } dsrb_state_e;

  typedef struct packed {
    logic serialClock;
    logic chipSelect_b;
    logic resync;
    logic dataIn;
    logic ioUpdate;
  } dsrb_pins_s;

  typedef struct packed {
    logic [31:0] controlWordOne;
    logic [23:0] controlWordTwo;
    logic [13:0] ampScale;
    logic [1:0]  rampSpeed;
    logic [7:0]  ampRampRate;
    logic [31:0] tuningWord;
    logic [13:0] phaseOffset;
    logic        pllBypass;
    logic [4:0]  pllMultiplier;
  } dsrb_active_s;

endpackage

// >>> src/dsrb_serial_bank.sv
// Purpose: Serially accessed configuration register bank
// Assumes: Serial clock far slower than ref_clk (160 ns period)
// Notes:   Writes land in a buffer; update pin makes them active
`timescale 1ns/1ps

module dsrb_serial_bank (
  input  wire logic           ref_clk,
  input  wire logic           rst_b,
  input  wire logic           serialClock,
  input  wire logic           chipSelectLow_b,
  input  wire logic           serialResyncInput,
  input  wire logic           serialDataIn,
  input  wire logic           ioUpdate,
  output logic                serialDataOut,
  output logic                serialDataOe,
  output logic                serialOutputPin,
  output dsrb_pkg::dsrb_active_s activeRegs
);
  import dsrb_pkg::*;

  // ==========================================================
  // Pin synchronisation
  dsrb_pins_s pinsRaw;
  dsrb_pins_s pinsSync;

  assign pinsRaw = '{serialClock:  serialClock,
                     chipSelect_b: chipSelectLow_b,
                     resync:       serialResyncInput,
                     dataIn:       serialDataIn,
                     ioUpdate:     ioUpdate};

  dsrb_sync uSync (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .din     (pinsRaw),
    .dout    (pinsSync)
  );

  // ==========================================================
  // Edge detection on synchronised pins
  logic sclkPrev_r;
  logic sclkPrev_nxt;
  logic updPrev_r;
  logic updPrev_nxt;
  logic sclkRise;
  logic updRise;
  logic frameAbort;

  always_comb begin
    sclkPrev_nxt = pinsSync.serialClock;
    updPrev_nxt  = pinsSync.ioUpdate;
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sclkPrev_r <= 1'b0;
      updPrev_r  <= 1'b0;
    end else begin
      sclkPrev_r <= sclkPrev_nxt;
      updPrev_r  <= updPrev_nxt;
    end
  end

  // Prev flops reset to the idle low level: no false edge
  assign sclkRise   = pinsSync.serialClock & ~sclkPrev_r;
  assign updRise    = pinsSync.ioUpdate & ~updPrev_r;
  // Host may tie select low (active) and resync low (inactive); either high aborts
  assign frameAbort = pinsSync.chipSelect_b | pinsSync.resync;

  // ==========================================================
  // Storage
  logic [DSRB_BYTE_W-1:0] bufByte_r    [DSRB_NUM_BYTES];
  logic [DSRB_BYTE_W-1:0] bufByte_nxt  [DSRB_NUM_BYTES];
  logic [DSRB_BYTE_W-1:0] actByte_r    [DSRB_NUM_BYTES];
  logic [DSRB_BYTE_W-1:0] actByte_nxt  [DSRB_NUM_BYTES];
  dsrb_active_s           activeRegs_r;
  dsrb_active_s           activeRegs_nxt;

  // Serial mode comes from the active copy only
  logic lsbFirst;
  logic inputOnly;
  assign lsbFirst  = actByte_r[DSRB_MODE_BYTE][DSRB_LSB_FIRST_BIT];
  assign inputOnly = actByte_r[DSRB_MODE_BYTE][DSRB_INPUT_ONLY_BIT];

  // ==========================================================
  // Shifter
  logic                   shiftEn;
  logic                   loadEn;
  logic [DSRB_BYTE_W-1:0] loadData;
  logic [DSRB_BYTE_W-1:0] shiftPar;
  logic                   shiftOut;

  // Data and clock pass the same synchroniser, so setup holds
  assign shiftEn = sclkRise & ~frameAbort;

  dsrb_shift uShift (
    .ref_clk  (ref_clk),
    .rst_b    (rst_b),
    .shiftEn  (shiftEn),
    .loadEn   (loadEn),
    .lsbFirst (lsbFirst),
    .serIn    (pinsSync.dataIn),
    .loadData (loadData),
    .parOut   (shiftPar),
    .serOut   (shiftOut)
  );

  // Internal byte of a register byte, in transfer order
  function automatic logic [3:0] byteAddr(input logic [2:0] sel,
                                          input logic [1:0] idx,
                                          input logic       lsb);
    logic [2:0] len;
    logic [2:0] ofs;
    len = DSRB_REG_LEN[sel];
    ofs = lsb ? {1'b0, idx} : 3'(len - 3'h1 - {1'b0, idx});
    return 4'(DSRB_REG_BASE[sel] + {1'b0, ofs});
  endfunction

  // ==========================================================
  // Serial engine
  dsrb_state_e state_r;
  dsrb_state_e state_nxt;
  logic [2:0]  bitCnt_r;
  logic [2:0]  bitCnt_nxt;
  logic        byteDone_r;
  logic        byteDone_nxt;
  logic [2:0]  regSel_r;
  logic [2:0]  regSel_nxt;
  logic [1:0]  byteIdx_r;
  logic [1:0]  byteIdx_nxt;
  logic        pinData_r;
  logic        pinData_nxt;
  logic        pinOe_r;
  logic        pinOe_nxt;
  logic        outPin_r;
  logic        outPin_nxt;

  always_comb begin
    logic [2:0] newSel;
    logic       lastByte;
    logic [3:0] curAddr;
    logic [4:0] pllField;
    newSel       = shiftPar[2:0];
    lastByte     = ({1'b0, byteIdx_r} == 3'(DSRB_REG_LEN[regSel_r] - 3'h1));
    curAddr      = byteAddr(regSel_r, byteIdx_r, lsbFirst);
    pllField     = 5'h00;
    state_nxt    = state_r;
    bitCnt_nxt   = bitCnt_r;
    byteDone_nxt = 1'b0;
    regSel_nxt   = regSel_r;
    byteIdx_nxt  = byteIdx_r;
    loadEn       = 1'b0;
    loadData     = DSRB_BYTE_RST;
    bufByte_nxt  = bufByte_r;
    actByte_nxt  = actByte_r;

    // Bit count restarts; a half-shifted byte is dropped
    if (frameAbort) begin
      state_nxt  = ST_INSTR;
      bitCnt_nxt = 3'h0;
    end else if (sclkRise) begin
      bitCnt_nxt   = 3'(bitCnt_r + 3'h1);
      byteDone_nxt = (bitCnt_r == 3'h7);
    end

    // Completed byte is one cycle behind its last clock edge
    if (byteDone_r && !frameAbort) begin
      unique case (state_r)
        ST_INSTR: begin
          // Unknown addresses are dropped; next byte is an instruction
          if (shiftPar[4:0] <= DSRB_ADDR_LAST) begin
            regSel_nxt  = newSel;
            byteIdx_nxt = 2'h0;
            if (shiftPar[DSRB_INSTR_READ_BIT]) begin
              state_nxt = ST_READ;
              loadEn    = 1'b1;
              loadData  = bufByte_r[byteAddr(newSel, 2'h0, lsbFirst)];
            end else begin
              state_nxt = ST_WRITE;
            end
          end
        end
        ST_WRITE: begin
          // Open bits masked on entry so they read back zero
          bufByte_nxt[curAddr] = shiftPar & DSRB_BYTE_MASK[curAddr];
          if (lastByte) begin
            state_nxt = ST_INSTR;
          end else begin
            byteIdx_nxt = 2'(byteIdx_r + 2'h1);
          end
        end
        ST_READ: begin
          // Next byte loads once the previous one has gone out
          if (lastByte) begin
            state_nxt = ST_INSTR;
          end else begin
            byteIdx_nxt = 2'(byteIdx_r + 2'h1);
            loadEn      = 1'b1;
            loadData    = bufByte_r[byteAddr(regSel_r,
                                             2'(byteIdx_r + 2'h1),
                                             lsbFirst)];
          end
        end
        default: begin
          state_nxt = ST_INSTR;
        end
      endcase
    end

    // Update copies the buffer as it stood before this cycle
    if (updRise) begin
      actByte_nxt = bufByte_r;
    end

    // Read data goes to the two-way pin or the separate output pin
    pinData_nxt = shiftOut;
    pinOe_nxt   = 1'b0;
    outPin_nxt  = 1'b0;
    if (state_nxt == ST_READ) begin
      if (inputOnly) begin
        outPin_nxt = shiftOut;
      end else begin
        pinOe_nxt = 1'b1;
      end
    end

    // Decoded view of the active bytes
    // Taken from the next bytes so it matches the active copy
    activeRegs_nxt.controlWordOne = {actByte_nxt[3], actByte_nxt[2],
                                     actByte_nxt[1], actByte_nxt[0]};
    activeRegs_nxt.controlWordTwo = {actByte_nxt[6], actByte_nxt[5],
                                     actByte_nxt[4]};
    activeRegs_nxt.ampScale       = {actByte_nxt[8][5:0],
                                     actByte_nxt[7]};
    activeRegs_nxt.rampSpeed      = actByte_nxt[8][7:6];
    activeRegs_nxt.ampRampRate    = actByte_nxt[9];
    activeRegs_nxt.tuningWord     = {actByte_nxt[13], actByte_nxt[12],
                                     actByte_nxt[11],
                                     actByte_nxt[10]};
    activeRegs_nxt.phaseOffset    = {actByte_nxt[15][5:0],
                                     actByte_nxt[14]};
    pllField = actByte_nxt[4][DSRB_PLL_MSB:DSRB_PLL_LSB];
    activeRegs_nxt.pllBypass      = (pllField < DSRB_PLL_MIN) ||
                                    (pllField > DSRB_PLL_MAX);
    activeRegs_nxt.pllMultiplier  = pllField;
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r      <= ST_INSTR;
      bitCnt_r     <= 3'h0;
      byteDone_r   <= 1'b0;
      regSel_r     <= 3'h0;
      byteIdx_r    <= 2'h0;
      pinData_r    <= 1'b0;
      pinOe_r      <= 1'b0;
      outPin_r     <= 1'b0;
      activeRegs_r <= '0;
      // Every byte clears, scale and ramp bytes included
      for (int i = 0; i < DSRB_NUM_BYTES; i++) begin
        bufByte_r[i] <= DSRB_BYTE_RST;
        actByte_r[i] <= DSRB_BYTE_RST;
      end
    end else begin
      state_r      <= state_nxt;
      bitCnt_r     <= bitCnt_nxt;
      byteDone_r   <= byteDone_nxt;
      regSel_r     <= regSel_nxt;
      byteIdx_r    <= byteIdx_nxt;
      pinData_r    <= pinData_nxt;
      pinOe_r      <= pinOe_nxt;
      outPin_r     <= outPin_nxt;
      activeRegs_r <= activeRegs_nxt;
      for (int i = 0; i < DSRB_NUM_BYTES; i++) begin
        bufByte_r[i] <= bufByte_nxt[i];
        actByte_r[i] <= actByte_nxt[i];
      end
    end
  end

  // ==========================================================
  // Outputs
  // Pins and decoded registers all come from flip-flops
  assign serialDataOut   = pinData_r;
  assign serialDataOe    = pinOe_r;
  assign serialOutputPin = outPin_r;
  assign activeRegs      = activeRegs_r;

endmodule

// >>> src/dsrb_shift.sv
// Purpose: Byte shifter shared by serial receive and transmit
// Assumes: Shift and load never requested in the same cycle
// Notes:   Order follows lsbFirst in both directions
`timescale 1ns/1ps
module dsrb_shift (
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  input  wire logic       shiftEn,
  input  wire logic       loadEn,
  input  wire logic       lsbFirst,
  input  wire logic       serIn,
  input  wire logic [7:0] loadData,
  output logic      [7:0] parOut,
  output logic            serOut
);
  import dsrb_pkg::*;

  logic [DSRB_BYTE_W-1:0] shift_r;
  logic [DSRB_BYTE_W-1:0] shift_nxt;

  // ==========================================================
  // Shift register
  always_comb begin
    shift_nxt = shift_r;
    if (loadEn) begin
      shift_nxt = loadData;
    end else if (shiftEn) begin
      shift_nxt = lsbFirst ? {serIn, shift_r[7:1]}
                           : {shift_r[6:0], serIn};
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      shift_r <= DSRB_BYTE_RST;
    end else begin
      shift_r <= shift_nxt;
    end
  end

  assign parOut = shift_r;
  assign serOut = lsbFirst ? shift_r[0] : shift_r[7];

endmodule

// >>> src/dsrb_sync.sv
// Purpose: Two-flop synchroniser for the serial port pins
// Assumes: Inputs are asynchronous to ref_clk
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
module dsrb_sync (
  input  wire logic                ref_clk,
  input  wire logic                rst_b,
  input  wire dsrb_pkg::dsrb_pins_s din,
  output dsrb_pkg::dsrb_pins_s     dout
);
  import dsrb_pkg::*;

  dsrb_pins_s meta_r;
  dsrb_pins_s meta_nxt;
  dsrb_pins_s stable_r;
  dsrb_pins_s stable_nxt;

  // ==========================================================
  // Two stages
  always_comb begin
    meta_nxt   = din;
    stable_nxt = meta_r;
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      // Select deasserted at reset so no frame starts
      meta_r   <= '{chipSelect_b: 1'b1, default: 1'b0};
      stable_r <= '{chipSelect_b: 1'b1, default: 1'b0};
    end else begin
      meta_r   <= meta_nxt;
      stable_r <= stable_nxt;
    end
  end

  assign dout = stable_r;

endmodule
